//--- logic/pim_consts.vh
// constants shared by the packet-driven i2c master
`ifndef PIM_CONSTS_VH
`define PIM_CONSTS_VH
// function codes, request and reply
`define PIM_FN_LREAD    16'h0001
`define PIM_FN_LWRITE   16'h0002
`define PIM_FN_LREAD_RE 16'h0003
`define PIM_FN_LWR_RE   16'h0004
`define PIM_FN_PROBE    16'h0005
`define PIM_FN_PROBE_RE 16'h0006
`define PIM_FN_COMB     16'h0007
`define PIM_FN_COMB_RE  16'h0008
// packet framing
`define PIM_HDR_LEN     8'h06
`define PIM_TRAIL       8'h02
`define PIM_PKT_OVH     16'h0008
`define PIM_MAX_PKT     8'hb4
`define PIM_PAIR        8'h02
`define PIM_YFLD        8'h01
// acknowledge-status byte
`define PIM_ST_INIT     8'h80
`define PIM_ST_WADDR    0
`define PIM_ST_WDATA    1
`define PIM_ST_RADDR    2
`define PIM_FILL        8'hff
// probe range
`define PIM_SCAN_FIRST  8'h01
`define PIM_SCAN_END    8'h80
// timing: 50 MHz clock over a 10 MHz divider reference
`define PIM_CLK_PER_REF 19'h00005
`define PIM_DIV_DEF     16'h0063
`endif

//--- logic/pim_mem.v
// byte buffer with one write port and a registered read port
`timescale 1ns/1ns
module pim_mem #(
	parameter DW = 8,
	parameter AW = 8
) (
	input  wire          i_mclk,
	input  wire          i_we,
	input  wire [AW-1:0] i_waddr,
	input  wire [DW-1:0] i_wdata,
	input  wire [AW-1:0] i_raddr,
	output reg  [DW-1:0] o_rdata
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge i_mclk) begin
		if (i_we)
			mem[i_waddr] <= i_wdata;
		o_rdata <= mem[i_raddr];
	end
endmodule // pim_mem

//--- logic/pim_ctrl.v
// packet command interpreter driving an i2c master, with reply builder
`timescale 1ns/1ns
`include "pim_consts.vh"
// Overview of operation
// - combined command 0x0007, groups addr/X/bytes/Y
// - several groups run in packet order
// - counts select read, write or write-read
// - write: start, address, acked bytes, stop
// - read: start, address, bytes, last nacked, stop
// - write-read uses repeated start before reading
// - reply 0x0008, tag, count, data+status per group
// - status bits: waddr, wdata, raddr, bit7 set
// - command split or malformed is discarded
// - legacy read 0x0001 answered 0x0003, no status
// - legacy write 0x0002 answered 0x0004, zero count
// - probe 0x0005 lists acking addresses, reply 0x0006
// - empty probe list scans addresses 1 to 127
// - bus rate from divider, rewritable any time
// - divider is volatile, reset to default
// - multi-byte fields travel high byte first
// - ones-complement 16-bit checksum on every packet
module pim_ctrl #(
	parameter DIV_DEF = `PIM_DIV_DEF
) (
	input  wire        i_mclk,
	input  wire        i_nrst,
	input  wire        i_rx_valid,
	input  wire [7:0]  i_rx_data,
	input  wire        i_rx_last,
	output reg         o_rx_ready,
	output reg         o_tx_valid,
	output reg  [7:0]  o_tx_data,
	output reg         o_tx_last,
	input  wire        i_tx_ready,
	input  wire        i_rate_wr,
	input  wire [15:0] i_rate_div,
	output reg  [15:0] o_rate_div,
	input  wire        i_scl_in,
	output reg         o_scl_out,
	output reg         o_scl_oe,
	input  wire        i_sda_in,
	output reg         o_sda_out,
	output reg         o_sda_oe,
	output reg         o_busy
);
	localparam S_RX = 7'h01, S_CHK = 7'h02, S_SEQ = 7'h04, S_FET = 7'h08;
	localparam S_BUS = 7'h10, S_SND = 7'h20, S_SND2 = 7'h40;
	localparam OP_START = 2'h0, OP_BYTE = 2'h1, OP_STOP = 2'h2;

	reg  [6:0]  state;
	reg  [4:0]  step;
	reg  [7:0]  n;
	reg         ovf;
	reg  [47:0] hdr;
	reg  [7:0]  p0, p1, rhi, thi;
	reg  [15:0] racc, tacc;
	reg  [7:0]  rp, ra, xcnt, ycnt, idx, st, m, twa, twd, sa;
	reg  [6:0]  gaddr;
	reg         wok, full, twe;
	reg  [8:0]  k;
	reg  [1:0]  q, bop;
	reg  [18:0] qt;
	reg  [3:0]  bit_n;
	reg  [8:0]  sh, rxs;
	reg  [7:0]  tb;
	wire [7:0]  rd, trd;
	wire [15:0] code = hdr[47:32];
	wire [15:0] len  = hdr[15:0];
	wire        rx_take = o_rx_ready & i_rx_valid;
	wire        ack = ~rxs[0];
	wire [8:0]  kp = k - 9'h006;
	wire [8:0]  mk = {1'b0, m};
	wire [18:0] qprod = ({3'b000, o_rate_div} + 19'h00001) * `PIM_CLK_PER_REF;
	wire [18:0] qlen = {2'b00, qprod[18:2]};
	wire        scl_rel = (q == 2'h1) | (q == 2'h2) |
	                      ((bop == OP_STOP) & (q == 2'h3));
	wire        sda_rel = (bop == OP_BYTE) ? sh[8] :
	                      (bop == OP_START) ? ~q[1] : q[1];
	wire [15:0] rfin, tfin;
	wire [47:0] rep, reps;

	// ****************************************
	// helpers
	// ****************************************
	// running sum of complemented words, carry folded back each add
	function [15:0] csum_add;
		input [15:0] acc;
		input [15:0] w;
		reg   [16:0] s;
		begin
			s = {1'b0, acc} + {1'b0, ~w};
			csum_add = s[15:0] + {15'h0000, s[16]};
		end
	endfunction

	// zero marks an unknown code
	function [15:0] reply_code;
		input [15:0] c;
		begin
			case (c)
			`PIM_FN_LREAD: reply_code = `PIM_FN_LREAD_RE;
			`PIM_FN_LWRITE: reply_code = `PIM_FN_LWR_RE;
			`PIM_FN_PROBE: reply_code = `PIM_FN_PROBE_RE;
			`PIM_FN_COMB: reply_code = `PIM_FN_COMB_RE;
			default: reply_code = 16'h0000;
			endcase
		end
	endfunction

	task bus;
		input [1:0] op;
		input [8:0] d;
		begin
			bop <= op;
			sh <= d;
			bit_n <= 4'h0;
			q <= 2'h0;
			qt <= qlen;
			state <= S_BUS;
		end
	endtask

	task fetch;
		input [7:0] a;
		begin
			ra <= a;
			state <= S_FET;
		end
	endtask

	task put;
		input [7:0] d;
		begin
			twe <= 1'b1;
			twa <= m;
			twd <= d;
			m <= m + 8'h01;
		end
	endtask

	task reply;
		begin
			k <= 9'h000;
			tacc <= 16'h0000;
			state <= S_SND;
		end
	endtask

	assign rfin = n[0] ? csum_add(racc, {rhi, 8'h00}) : racc;
	assign tfin = m[0] ? csum_add(tacc, {thi, 8'h00}) : tacc;
	assign rep  = {reply_code(code), hdr[31:16], 8'h00, m};
	assign reps = rep << {k[2:0], 3'b000};

	always @* begin
		if (k < 9'h006)
			tb = reps[47:40];
		else if (k < mk + 9'h006)
			tb = trd;
		else if (k == mk + 9'h006)
			tb = tfin[15:8];
		else
			tb = tfin[7:0];
	end

	pim_mem #(.DW(8), .AW(8)) u_rxbuf (
		.i_mclk  (i_mclk),
		.i_we    (rx_take & ~ovf),
		.i_waddr (n),
		.i_wdata (i_rx_data),
		.i_raddr (ra),
		.o_rdata (rd)
	);

	pim_mem #(.DW(8), .AW(8)) u_txbuf (
		.i_mclk  (i_mclk),
		.i_we    (twe),
		.i_waddr (twa),
		.i_wdata (twd),
		.i_raddr (kp[7:0]),
		.o_rdata (trd)
	);

	// ****************************************
	// control
	// ****************************************
	always @(posedge i_mclk) begin
		if (!i_nrst) begin
			state <= S_RX; step <= 5'h00; n <= 8'h00; ovf <= 1'b0;
			hdr <= 48'h0; p0 <= 8'h00; p1 <= 8'h00; rhi <= 8'h00;
			thi <= 8'h00; racc <= 16'h0000; tacc <= 16'h0000;
			rp <= 8'h00; ra <= 8'h00; xcnt <= 8'h00; ycnt <= 8'h00;
			idx <= 8'h00; st <= `PIM_ST_INIT; m <= 8'h00; twa <= 8'h00;
			twd <= 8'h00; sa <= 8'h00; gaddr <= 7'h00; wok <= 1'b0;
			full <= 1'b0; twe <= 1'b0; k <= 9'h000; q <= 2'h0;
			bop <= OP_STOP; qt <= 19'h00000; bit_n <= 4'h0;
			sh <= 9'h1ff; rxs <= 9'h1ff;
			o_rx_ready <= 1'b1; o_tx_valid <= 1'b0; o_tx_data <= 8'h00;
			o_tx_last <= 1'b0; o_scl_out <= 1'b0; o_scl_oe <= 1'b0;
			o_sda_out <= 1'b0; o_sda_oe <= 1'b0; o_busy <= 1'b0;
			o_rate_div <= DIV_DEF;
		end else begin
			twe <= 1'b0;
			o_busy <= (state != S_RX);
			if (i_rate_wr)
				o_rate_div <= i_rate_div;
			if (i_tx_ready)
				o_tx_valid <= 1'b0;
			if (state == S_BUS) begin
				o_scl_oe <= ~scl_rel;
				o_sda_oe <= ~sda_rel;
			end
			case (state)
			S_RX: if (rx_take) begin
				if (n == 8'hff)
					ovf <= 1'b1;
				else
					n <= n + 8'h01;
				if (n < `PIM_HDR_LEN)
					hdr <= {hdr[39:0], i_rx_data};
				p0 <= i_rx_data;
				p1 <= p0;
				// two-byte delay keeps the trailing checksum out of the sum
				if (n >= `PIM_TRAIL) begin
					if (!n[0])
						rhi <= p1;
					else
						racc <= csum_add(racc, {rhi, p1});
				end
				if (i_rx_last) begin
					o_rx_ready <= 1'b0;
					state <= S_CHK;
				end
			end
			S_CHK: begin
				n <= 8'h00;
				ovf <= 1'b0;
				racc <= 16'h0000;
				rp <= `PIM_HDR_LEN;
				m <= 8'h00;
				idx <= 8'h00;
				sa <= `PIM_SCAN_FIRST;
				full <= (len == 16'h0000);
				step <= (code == `PIM_FN_PROBE) ? 5'h11 : 5'h00;
				// one packet must hold exactly one whole command
				if (!ovf && {8'h00, n} == len + `PIM_PKT_OVH &&
				    n <= `PIM_MAX_PKT && rfin == {p1, p0} &&
				    reply_code(code) != 16'h0000) begin
					state <= S_SEQ;
				end else begin
					o_rx_ready <= 1'b1;
					state <= S_RX;
				end
			end
			S_FET: state <= S_SEQ;
			S_BUS: if (qt != 19'h00000) begin
				// clock stretching: a held-low scl freezes the quarter
				if (!(scl_rel & ~i_scl_in))
					qt <= qt - 19'h00001;
			end else begin
				qt <= qlen;
				q <= q + 2'h1;
				if (q == 2'h2)
					rxs <= {rxs[7:0], i_sda_in};
				if (q == 2'h3) begin
					sh <= {sh[7:0], 1'b1};
					bit_n <= bit_n + 4'h1;
					if (bop != OP_BYTE || bit_n == 4'h8)
						state <= S_SEQ;
				end
			end
			S_SEQ: case (step)
			5'h00: if ({8'h00, rp} >= len + {8'h00, `PIM_HDR_LEN}) begin
				reply;
			end else begin
				fetch(rp);
				step <= 5'h01;
			end
			5'h01: begin
				gaddr <= rd[6:0];
				fetch(rp + 8'h01);
				step <= 5'h02;
			end
			5'h02: begin
				xcnt <= rd;
				if (code == `PIM_FN_LWRITE) begin
					ycnt <= 8'h00;
					step <= 5'h04;
				end else begin
					fetch(rp + `PIM_PAIR + rd);
					step <= 5'h03;
				end
			end
			5'h03: begin
				ycnt <= rd;
				step <= 5'h04;
			end
			5'h04: begin
				st <= `PIM_ST_INIT;
				wok <= 1'b1;
				idx <= 8'h00;
				if (xcnt != 8'h00) begin
					bus(OP_START, 9'h1ff);
					step <= 5'h05;
				end else
					step <= 5'h08;
			end
			5'h05: begin
				bus(OP_BYTE, {gaddr, 1'b0, 1'b1});
				step <= 5'h06;
			end
			5'h06: begin
				st[`PIM_ST_WADDR] <= ack;
				if (!ack) begin
					bus(OP_STOP, 9'h1ff);
					step <= 5'h0d;
				end else
					step <= 5'h07;
			end
			5'h07: if (idx != xcnt) begin
				fetch(rp + `PIM_PAIR + idx);
				step <= 5'h0e;
			end else
				step <= 5'h08;
			5'h0e: begin
				bus(OP_BYTE, {rd, 1'b1});
				idx <= idx + 8'h01;
				step <= 5'h0f;
			end
			5'h0f: begin
				if (!ack)
					wok <= 1'b0;
				step <= 5'h07;
			end
			5'h08: begin
				st[`PIM_ST_WDATA] <= (xcnt != 8'h00) & wok;
				idx <= 8'h00;
				if (ycnt != 8'h00) begin
					bus(OP_START, 9'h1ff);
					step <= 5'h09;
				end else begin
					if (xcnt != 8'h00)
						bus(OP_STOP, 9'h1ff);
					step <= 5'h0c;
				end
			end
			5'h09: begin
				bus(OP_BYTE, {gaddr, 1'b1, 1'b1});
				step <= 5'h0a;
			end
			5'h0a: begin
				st[`PIM_ST_RADDR] <= ack;
				if (!ack) begin
					bus(OP_STOP, 9'h1ff);
					step <= 5'h0d;
				end else
					step <= 5'h0b;
			end
			5'h0b: if (idx != ycnt) begin
				// last byte released high, i.e. not acknowledged
				bus(OP_BYTE, {8'hff, idx == ycnt - 8'h01});
				idx <= idx + 8'h01;
				step <= 5'h10;
			end else begin
				bus(OP_STOP, 9'h1ff);
				step <= 5'h0c;
			end
			5'h10: begin
				put(rxs[8:1]);
				step <= 5'h0b;
			end
			// filler keeps the reply layout when a read is skipped
			5'h0d: if (idx != ycnt) begin
				put(`PIM_FILL);
				idx <= idx + 8'h01;
			end else
				step <= 5'h0c;
			5'h0c: begin
				if (code == `PIM_FN_COMB)
					put(st);
				rp <= rp + `PIM_PAIR + xcnt +
				      ((code == `PIM_FN_LWRITE) ? 8'h00 : `PIM_YFLD);
				step <= 5'h00;
			end
			5'h11: if (full) begin
				if (sa == `PIM_SCAN_END)
					reply;
				else begin
					gaddr <= sa[6:0];
					sa <= sa + 8'h01;
					bus(OP_START, 9'h1ff);
					step <= 5'h13;
				end
			end else if ({8'h00, idx} == len)
				reply;
			else begin
				fetch(`PIM_HDR_LEN + idx);
				step <= 5'h12;
			end
			5'h12: begin
				gaddr <= rd[6:0];
				idx <= idx + 8'h01;
				bus(OP_START, 9'h1ff);
				step <= 5'h13;
			end
			5'h13: begin
				bus(OP_BYTE, {gaddr, 1'b0, 1'b1});
				step <= 5'h14;
			end
			5'h14: begin
				if (ack)
					put({1'b0, gaddr});
				bus(OP_STOP, 9'h1ff);
				step <= 5'h11;
			end
			default: step <= 5'h00;
			endcase
			S_SND: state <= S_SND2;
			S_SND2: if (!o_tx_valid || i_tx_ready) begin
				o_tx_valid <= 1'b1;
				o_tx_data <= tb;
				o_tx_last <= (k == mk + 9'h007);
				k <= k + 9'h001;
				if (k < mk + 9'h006) begin
					if (!k[0])
						thi <= tb;
					else
						tacc <= csum_add(tacc, {thi, tb});
				end
				if (k == mk + 9'h007) begin
					o_rx_ready <= 1'b1;
					state <= S_RX;
				end else
					state <= S_SND;
			end
			default: state <= S_RX;
			endcase
		end
	end
endmodule // pim_ctrl

//--- tb/pim_ctrl_properties.sv
// assertions on the ports of the packet-driven i2c master
`timescale 1ns/1ns
module pim_ctrl_chk #(
	parameter [15:0] DIV_DEF = 16'h0063
) (
	input wire        i_mclk,
	input wire        i_nrst,
	input wire        i_rx_valid,
	input wire        i_rx_last,
	input wire        o_rx_ready,
	input wire        o_tx_valid,
	input wire [7:0]  o_tx_data,
	input wire        o_tx_last,
	input wire        i_tx_ready,
	input wire        i_rate_wr,
	input wire [15:0] i_rate_div,
	input wire [15:0] o_rate_div,
	input wire        o_scl_out,
	input wire        o_scl_oe,
	input wire        o_sda_out,
	input wire        o_sda_oe,
	input wire        o_busy
);
	// ****
	// port relations
	// ****
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	reset_state_a: assert property (disable iff (1'b0)
		!i_nrst |=> o_rx_ready && !o_tx_valid && !o_busy && !o_scl_oe
		&& !o_sda_oe && o_rate_div == DIV_DEF) else $error("reset state");
	rate_load_a: assert property (
		i_rate_wr |=> o_rate_div == $past(i_rate_div)) else $error("divider");
	reply_hold_a: assert property (
		o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data)
		&& $stable(o_tx_last)) else $error("reply byte dropped");
	// a byte may be reloaded on the edge that takes the previous one,
	// so only the end of the reply is bound to drop valid
	reply_gap_a: assert property (
		o_tx_valid && i_tx_ready && o_tx_last |=> !o_tx_valid)
		else $error("reply runs past its last byte");
	packet_end_a: assert property (
		i_rx_valid && o_rx_ready && i_rx_last |=> !o_rx_ready)
		else $error("byte taken past packet end");
	reply_busy_a: assert property (
		o_tx_valid && !o_tx_last |-> !o_rx_ready) else $error("rx open early");
	reply_end_a: assert property (
		o_tx_valid && o_tx_last |-> o_rx_ready) else $error("rx not reopened");
	bus_busy_a: assert property (
		o_scl_oe || o_sda_oe |-> o_busy) else $error("bus driven while idle");
	pin_low_a: assert property (
		!o_scl_out && !o_sda_out) else $error("open-drain pin driven high");
endmodule // pim_ctrl_chk

//--- tb/pim_slave.sv
// i2c slave model: acks one address, reads back a counting pattern
`timescale 1ns/1ns
module pim_slave #(
	parameter [6:0] ADDR = 7'h28
) (
	input  wire i_scl,
	input  wire i_sda,
	output reg  o_sda_oe
);
	reg [7:0] sh = 0;
	reg [7:0] tx = 0;
	reg [7:0] cnt = 0;
	reg [3:0] n = 0;
	reg       hdr = 0;
	reg       act = 0;
	reg       rd = 0;
	reg       snd = 0;
	initial o_sda_oe = 0;
	// ****
	// bus conditions
	// ****
	// a repeated start rearms the address phase and the read pattern
	always @(negedge i_sda) if (i_scl) begin
		n = 0;
		hdr = 1;
		cnt = 8'hc0;
		snd = 0;
	end
	always @(posedge i_sda) if (i_scl) begin
		hdr = 0;
		act = 0;
	end
	always @(posedge i_scl) begin
		sh = {sh[6:0], i_sda};
		n = n + 1;
	end
	// only changes sda while scl is low, so no false start or stop
	always @(negedge i_scl) begin
		if (n == 8) begin
			if (hdr) begin
				act = sh[7:1] == ADDR;
				rd = sh[0];
				hdr = 0;
				o_sda_oe = act;
			end else
				o_sda_oe = act && !rd;
			snd = 0;
		end else if (n == 9) begin
			n = 0;
			snd = act && rd && !sh[0];
			tx = cnt;
			cnt = cnt + 8'h01;
			o_sda_oe = snd && !tx[7];
		end else if (snd)
			o_sda_oe = !tx[7 - n];
	end
endmodule // pim_slave

//--- tb/test_pim_ctrl.sv
// bench: packets in, slave model on the wires, replies checked
`timescale 1ns/1ns
module test_pim_ctrl;
	reg         i_mclk = 0;
	reg         i_nrst = 0;
	reg         rx_valid = 0;
	reg         rx_last = 0;
	reg         tx_ready = 0;
	reg         rate_wr = 0;
	reg         got = 0;
	reg  [7:0]  rx_data = 0;
	reg  [15:0] rate_div = 0;
	reg  [15:0] tg = 16'h1b00;
	reg  [47:0] rows [0:7];
	reg  [7:0]  pk [$];
	reg  [7:0]  ex [$];
	reg  [7:0]  rp [$];
	reg  [7:0]  cq [$];
	wire        rx_ready, tx_valid, tx_last, scl_oe, sda_oe, s_oe;
	wire [7:0]  tx_data;
	wire [15:0] rate_q;
	wire        scl = !scl_oe;
	wire        sda = !(sda_oe | s_oe);
	integer     fail_count = 0;
	integer     samples_checked = 0;
	integer     i;
	pim_ctrl uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_rx_valid(rx_valid),
		.i_rx_data(rx_data), .i_rx_last(rx_last), .o_rx_ready(rx_ready),
		.o_tx_valid(tx_valid), .o_tx_data(tx_data), .o_tx_last(tx_last),
		.i_tx_ready(tx_ready), .i_rate_wr(rate_wr), .i_rate_div(rate_div),
		.o_rate_div(rate_q), .i_scl_in(scl), .o_scl_out(), .o_scl_oe(scl_oe),
		.i_sda_in(sda), .o_sda_out(), .o_sda_oe(sda_oe), .o_busy());
	pim_slave slave (.i_scl(scl), .i_sda(sda), .o_sda_oe(s_oe));
	always #10 i_mclk = ~i_mclk;
	// stall every other cycle so each reply byte must hold
	always @(posedge i_mclk) tx_ready <= ~tx_ready;
	always @(posedge i_mclk) if (tx_valid && tx_ready) begin
		rp.push_back(tx_data);
		if (tx_last)
			got = 1;
	end
	// ****
	// helpers
	// ****
	function [15:0] cks(input integer n);
		reg [31:0] s;
		integer    k;
		begin
			s = 0;
			for (k = 0; k < n; k++)
				s += k[0] ? {24'h0, ~cq[k]} : {16'h0, ~cq[k], 8'h00};
			if (n[0])
				s += 32'hff;
			s = s[31:16] + s[15:0];
			cks = s[31:16] + s[15:0];
		end
	endfunction
	task cmp(input [15:0] g, input [15:0] e);
		begin
			samples_checked++;
			if (g !== e) begin
				fail_count++;
				$display("Error %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task hdr(input [7:0] c);
		begin
			pk = {8'h00, c, tg[15:8], tg[7:0], 8'h00, 8'h00};
			ex = {};
		end
	endtask
	task grp(input [7:0] c, a, x, y, st);
		integer j;
		begin
			pk.push_back(a);
			if (c != 5)
				pk.push_back(x);
			for (j = 0; j < x; j++)
				pk.push_back(8'h1a + 8'h11 * j[7:0]);
			if (c == 7 || c == 1)
				pk.push_back(y);
			for (j = 0; j < y; j++)
				ex.push_back(a == 8'h28 ? 8'hc0 + j[7:0] : 8'hff);
			if (c == 7)
				ex.push_back(st);
			if (c == 5 && a == 8'h28)
				ex.push_back(a);
		end
	endtask
	task go(input [7:0] ec, input integer cut, input [7:0] bad);
		integer    k;
		reg [15:0] s;
		begin
			pk[5] = 8'(pk.size() - 6);
			cq = pk;
			s = cks(pk.size());
			pk.push_back(s[15:8]);
			pk.push_back(s[7:0] ^ bad);
			rp = {};
			got = 0;
			for (k = 0; k < pk.size(); k++) begin
				rx_valid <= 1;
				rx_data <= pk[k];
				rx_last <= (k == cut) || (k == pk.size() - 1);
				@(posedge i_mclk);
				while (!rx_ready) @(posedge i_mclk);
			end
			rx_valid <= 0;
			rx_last <= 0;
			for (k = 0; k < 60000 && !got && ec; k++) @(posedge i_mclk);
			repeat (ec ? 4 : 3000) @(posedge i_mclk);
			cq = {8'h00, ec, tg[15:8], tg[7:0], 8'h00, 8'(ex.size())};
			for (k = 0; k < ex.size(); k++)
				cq.push_back(ex[k]);
			s = cks(cq.size());
			cq.push_back(s[15:8]);
			cq.push_back(s[7:0]);
			if (ec == 0)
				cq = {};
			cmp(rp.size(), cq.size());
			for (k = 0; k < cq.size() && k < rp.size(); k++)
				cmp(rp[k], cq[k]);
			tg++;
		end
	endtask
	task results;
		begin
			$display("checks %0d errors %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// ****
	// sequence
	// ****
	// about 95k cycles; the scenarios need roughly 50k, the full probe most
	initial begin
		#1_900_000;
		fail_count++;
		results;
	end
	initial begin
		rows[0] = 48'h07_08_28_02_00_83;
		rows[1] = 48'h07_08_28_00_02_84;
		rows[2] = 48'h07_08_28_01_01_87;
		rows[3] = 48'h07_08_30_01_02_80;
		rows[4] = 48'h01_03_28_00_02_00;
		rows[5] = 48'h02_04_28_02_00_00;
		rows[6] = 48'h05_06_28_00_00_00;
		rows[7] = 48'h05_06_30_00_00_00;
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1;
		cmp(rate_q, 16'h0063);
		rate_div <= 16'h0003;
		rate_wr <= 1;
		@(posedge i_mclk);
		rate_wr <= 0;
		@(posedge i_mclk);
		cmp(rate_q, 16'h0003);
		for (i = 0; i < 8; i++) begin
			hdr(rows[i][47:40]);
			grp(rows[i][47:40], rows[i][31:24], rows[i][23:16],
				rows[i][15:8], rows[i][7:0]);
			go(rows[i][39:32], -1, 0);
		end
		hdr(7);
		grp(7, 8'h28, 2, 0, 8'h83);
		grp(7, 8'h30, 0, 1, 8'h80);
		grp(7, 8'h28, 1, 2, 8'h87);
		go(8, -1, 0);
		hdr(5);
		ex.push_back(8'h28);
		go(6, -1, 0);
		hdr(7);
		grp(7, 8'h28, 1, 1, 8'h87);
		ex = {};
		go(0, 4, 0);
		hdr(1);
		grp(1, 8'h28, 0, 1, 8'h00);
		ex = {};
		go(0, -1, 8'h01);
		// unknown function code: well formed, still no reply
		hdr(8'h09);
		go(0, -1, 0);
		i_nrst <= 0;
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1;
		@(posedge i_mclk);
		cmp(rate_q, 16'h0063);
		results;
	end
endmodule // test_pim_ctrl
bind pim_ctrl pim_ctrl_chk #(.DIV_DEF(DIV_DEF)) chk (.i_mclk(i_mclk),
	.i_nrst(i_nrst), .i_rx_valid(i_rx_valid), .i_rx_last(i_rx_last),
	.o_rx_ready(o_rx_ready), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
	.o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready), .i_rate_wr(i_rate_wr),
	.i_rate_div(i_rate_div), .o_rate_div(o_rate_div), .o_scl_oe(o_scl_oe),
	.o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out), .o_sda_out(o_sda_out),
	.o_busy(o_busy));
